// >>> refclk_pkg.sv
// Package for the reference clock source, trim and clock status block.
// Assumes a 32-bit APB slave on the system clock, one word per register.
package refclk_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_REF_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_REF_CLOCK_TRIM = 8'h04;
  localparam logic [7:0] ADDR_CLOCK_READY_STATUS = 8'h08;
  localparam logic [7:0] ADDR_FAST_RC_TUNING = 8'h0C;
  localparam logic [7:0] ADDR_UNLOCK = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIV_LSB = 16;
  localparam int DIV_MSB = 30;
  localparam int ON_BIT = 15;
  localparam int SIDL_BIT = 13;
  localparam int OE_BIT = 12;
  localparam int REF_RUN_IN_SLEEP_BIT = 11;
  localparam int SWREQ_BIT = 9;
  localparam int ACTIVE_BIT = 8;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 3;
  localparam int TRIM_LSB = 23;
  localparam int TRIM_MSB = 31;
  localparam int TUNE_MSB = 5;
  localparam int DIV_W = 15;
  localparam int TRIM_W = 9;
  localparam int TUNE_W = 6;

  // Status bit positions
  localparam int ST_PLL_LOCK = 7;
  localparam int ST_LOWPOWER_RC_OSCILLATOR = 5;
  localparam int ST_SECONDARY_OSCILLATOR = 4;
  localparam int ST_PRIMARY_OSCILLATOR = 2;
  localparam int ST_PDIV = 1;
  localparam int ST_FRC = 0;
  localparam logic [7:0] STATUS_IMPL_MASK = 8'hB7;

  // Unlock sequence keys (arbitrary values)
  localparam logic [31:0] UNLOCK_KEY1 = 32'hAA99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99AA;

  localparam logic [TUNE_W-1:0] TUNE_RESET = 6'h00;

  // Interrupt event layout
  localparam int IRQ_SWITCH_DONE = 0;
  localparam int IRQ_READY_CHANGE = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------------------------------
  // Source selector codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_SYS0 = 4'h0,
    SRC_SYS1 = 4'h1,
    SRC_PRIMARY = 4'h2,
    SRC_FAST_RC = 4'h3,
    SRC_LOWPOWER_RC = 4'h4,
    SRC_SECONDARY = 4'h5,
    SRC_PLL = 4'h7,
    SRC_PIN = 4'h9
  } src_sel_t;

  typedef struct packed {
    logic pll_lock_flag;
    logic lowpower_rc_ready;
    logic secondary_osc_ready;
    logic primary_osc_ready;
    logic pll_postscaler_ready;
    logic fast_rc_ready;
  } ready_t;

  typedef struct packed {
    logic system_clock;
    logic primary_oscillator;
    logic fast_rc_oscillator;
    logic lowpower_rc_oscillator;
    logic secondary_oscillator;
    logic pll_output;
    logic ref_clock_input_pin;
  } src_edges_t;

endpackage : refclk_pkg

// >>> refclk_sync3.sv
// Three-stage synchroniser for a bundle of asynchronous levels.
// A change is accepted only when the second and third stages agree.
`timescale 1ns/100ps
module refclk_sync3 #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Filtered levels
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_agree
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q[i] <= 1'b0;
        end else if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule : refclk_sync3

// >>> refclk_divider.sv
// Fractional divider: source edge pulses in, one output toggle per half period.
// Assumes one-cycle source enables on the system clock; divisor loaded on switch.
`timescale 1ns/100ps
module refclk_divider #(
  parameter int DIV_W = 15,
  parameter int TRIM_W = 9
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic run, // Module running
  input wire logic src_tick, // Selected source edge
  input wire logic load, // Take new divisor
  input wire logic [DIV_W-1:0] div_int, // Integer divisor
  input wire logic [TRIM_W-1:0] div_frac, // Fraction in 1/512 units
  output logic clk_out, // Divided reference level
  output logic loaded // High the cycle after each load cycle: divisor taken
);
  logic [DIV_W-1:0] int_r;
  logic [TRIM_W-1:0] frac_r;
  logic [TRIM_W-1:0] acc_r;
  logic [DIV_W:0] cnt_r;
  logic [TRIM_W:0] acc_sum;
  logic [DIV_W:0] limit;
  logic [DIV_W:0] cnt_inc;

  // Carry out of the fraction accumulator stretches one half period
  assign acc_sum = {1'b0, acc_r} + {1'b0, frac_r};
  assign limit = {1'b0, int_r} + {{DIV_W{1'b0}}, acc_sum[TRIM_W]};
  assign cnt_inc = cnt_r + {{DIV_W{1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_r <= '0;
      frac_r <= '0;
      loaded <= 1'b0;
    end else begin
      loaded <= load;
      if (load) begin
        int_r <= div_int;
        frac_r <= (div_int == '0) ? '0 : div_frac;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      acc_r <= '0;
      clk_out <= 1'b0;
    end else if (!run || load) begin
      cnt_r <= '0;
      acc_r <= '0;
      clk_out <= 1'b0;
    end else if (src_tick) begin
      if (int_r == '0) begin
        clk_out <= ~clk_out;
      end else if (cnt_inc >= limit) begin
        cnt_r <= '0;
        acc_r <= acc_sum[TRIM_W-1:0];
        clk_out <= ~clk_out;
      end else begin
        cnt_r <= cnt_inc;
      end
    end
  end
endmodule : refclk_divider

// >>> refclk_top.sv
// Reference clock source select, fractional trim, ready status and RC tuning.
// Assumes an APB master on SYS_CLK; sources arrive as level clocks from pins.
`timescale 1ns/100ps

module refclk_top (
  input wire logic SYS_CLK, // System clock, 10 MHz
  input wire logic RESET_N, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB write
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error
  input wire logic SLEEP_REQ, // Device in sleep
  input wire logic IDLE_REQ, // Device in idle
  input wire logic [6:0] SRC_CLK_IN, // Source clocks, asynchronous
  input wire logic [5:0] READY_IN, // Oscillator ready levels, asynchronous
  output logic REF_CLK_OUT, // Reference clock output
  output logic REF_CLK_OE, // Reference pin output enable
  output logic [5:0] FAST_RC_TUNE, // Tuning code to the fast RC
  output logic IRQ // Interrupt, level
);
  // ----------------------------------------------------------------
  // Synchronised inputs
  // ----------------------------------------------------------------
  logic [6:0] src_lvl;
  logic [6:0] src_prev_r;
  logic [5:0] rdy_lvl;
  refclk_pkg::src_edges_t src_rise;
  refclk_pkg::ready_t rdy;

  refclk_sync3 #(.W(7)) u_src_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .d(SRC_CLK_IN),
    .q(src_lvl)
  );

  refclk_sync3 #(.W(6)) u_rdy_sync (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .d(READY_IN),
    .q(rdy_lvl)
  );

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      src_prev_r <= '0;
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  // Bit 6 is the system clock itself: every cycle is a tick
  assign src_rise = {1'b1, src_lvl[5:0] & ~src_prev_r[5:0]};
  assign rdy = rdy_lvl;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [refclk_pkg::DIV_W-1:0] div_r;
  logic on_r;
  logic sidl_r;
  logic oe_r;
  logic ref_run_in_sleep_r;
  logic swreq_r;
  logic active_r;
  logic [3:0] sel_r;
  logic [refclk_pkg::TRIM_W-1:0] trim_r;
  logic [refclk_pkg::TUNE_W-1:0] tune_r;
  logic [7:0] status_r;
  logic [7:0] status_prev_r;
  logic [1:0] unlock_r;
  logic [refclk_pkg::IRQ_W-1:0] irq_stat_r;
  logic [refclk_pkg::IRQ_W-1:0] irq_mask_r;
  logic [refclk_pkg::IRQ_W-1:0] irq_evt;
  logic wr_en;
  logic rd_en;
  logic div_loaded;
  logic div_clk;
  logic run;
  logic src_tick;
  logic [31:0] rd_nxt;

  // Single-cycle access phase, no wait states
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == refclk_pkg::ADDR_REF_CLOCK_CONTROL) ||
                 (a == refclk_pkg::ADDR_REF_CLOCK_TRIM) ||
                 (a == refclk_pkg::ADDR_CLOCK_READY_STATUS) ||
                 (a == refclk_pkg::ADDR_FAST_RC_TUNING) ||
                 (a == refclk_pkg::ADDR_UNLOCK) ||
                 (a == refclk_pkg::ADDR_IRQ_STATUS) ||
                 (a == refclk_pkg::ADDR_IRQ_MASK);
  endfunction : addr_known

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_r <= '0;
      on_r <= 1'b0;
      sidl_r <= 1'b0;
      oe_r <= 1'b0;
      ref_run_in_sleep_r <= 1'b0;
      sel_r <= refclk_pkg::SRC_SYS0;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_REF_CLOCK_CONTROL) begin
      // Writes while enable and request differ are the caller's fault
      div_r <= PWDATA[refclk_pkg::DIV_MSB:refclk_pkg::DIV_LSB];
      on_r <= PWDATA[refclk_pkg::ON_BIT];
      sidl_r <= PWDATA[refclk_pkg::SIDL_BIT];
      oe_r <= PWDATA[refclk_pkg::OE_BIT];
      ref_run_in_sleep_r <= PWDATA[refclk_pkg::REF_RUN_IN_SLEEP_BIT];
      sel_r <= PWDATA[refclk_pkg::SEL_MSB:refclk_pkg::SEL_LSB];
    end
  end

  // Switch request: set by software, cleared once the divider took it
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      swreq_r <= 1'b0;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_REF_CLOCK_CONTROL &&
                 PWDATA[refclk_pkg::SWREQ_BIT]) begin
      swreq_r <= 1'b1;
    end else if (div_loaded) begin
      swreq_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Trim and tuning
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      trim_r <= '0;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_REF_CLOCK_TRIM) begin
      trim_r <= PWDATA[refclk_pkg::TRIM_MSB:refclk_pkg::TRIM_LSB];
    end
  end

  // Unlock: key1 then key2; any other bus write in between breaks it
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      unlock_r <= 2'h0;
    end else if (wr_en) begin
      if (PADDR == refclk_pkg::ADDR_UNLOCK && PWDATA == refclk_pkg::UNLOCK_KEY1) begin
        unlock_r <= 2'h1;
      end else if (PADDR == refclk_pkg::ADDR_UNLOCK && unlock_r == 2'h1 &&
                   PWDATA == refclk_pkg::UNLOCK_KEY2) begin
        unlock_r <= 2'h2;
      end else if (PADDR == refclk_pkg::ADDR_FAST_RC_TUNING) begin
        unlock_r <= 2'h0;
      end else if (unlock_r != 2'h2) begin
        unlock_r <= 2'h0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tune_r <= refclk_pkg::TUNE_RESET;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_FAST_RC_TUNING && unlock_r == 2'h2) begin
      tune_r <= PWDATA[refclk_pkg::TUNE_MSB:0];
    end
  end

  // Two's complement code goes straight to the oscillator trim DAC
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_RC_TUNE <= refclk_pkg::TUNE_RESET;
    end else begin
      FAST_RC_TUNE <= tune_r;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_r <= 8'h00;
      status_prev_r <= 8'h00;
    end else begin
      status_prev_r <= status_r;
      status_r <= 8'h00;
      status_r[refclk_pkg::ST_PLL_LOCK] <= rdy.pll_lock_flag;
      status_r[refclk_pkg::ST_LOWPOWER_RC_OSCILLATOR] <= rdy.lowpower_rc_ready;
      status_r[refclk_pkg::ST_SECONDARY_OSCILLATOR] <= rdy.secondary_osc_ready;
      status_r[refclk_pkg::ST_PRIMARY_OSCILLATOR] <= rdy.primary_osc_ready;
      status_r[refclk_pkg::ST_PDIV] <= rdy.pll_postscaler_ready;
      status_r[refclk_pkg::ST_FRC] <= rdy.fast_rc_ready;
    end
  end

  // ----------------------------------------------------------------
  // Source select and divider
  // ----------------------------------------------------------------
  always_comb begin
    case (sel_r)
      refclk_pkg::SRC_SYS0: src_tick = src_rise.system_clock;
      refclk_pkg::SRC_SYS1: src_tick = src_rise.system_clock;
      refclk_pkg::SRC_PRIMARY: src_tick = src_rise.primary_oscillator;
      refclk_pkg::SRC_FAST_RC: src_tick = src_rise.fast_rc_oscillator;
      refclk_pkg::SRC_LOWPOWER_RC: src_tick = src_rise.lowpower_rc_oscillator;
      refclk_pkg::SRC_SECONDARY: src_tick = src_rise.secondary_oscillator;
      refclk_pkg::SRC_PLL: src_tick = src_rise.pll_output;
      refclk_pkg::SRC_PIN: src_tick = src_rise.ref_clock_input_pin;
      default: src_tick = 1'b0; // Reserved codes give no clock
    endcase
  end

  // Sleep stops the output unless run-in-sleep applies; ignored for code 0000
  assign run = on_r && !(IDLE_REQ && sidl_r) &&
               !(SLEEP_REQ && !(ref_run_in_sleep_r && sel_r != refclk_pkg::SRC_SYS0));

  // Request status follows enable one cycle later
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      active_r <= 1'b0;
    end else begin
      active_r <= on_r;
    end
  end

  // Load when idle, or on an explicit switch request while enabled
  refclk_divider #(
    .DIV_W(refclk_pkg::DIV_W),
    .TRIM_W(refclk_pkg::TRIM_W)
  ) u_div (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .run(run),
    .src_tick(src_tick),
    .load(swreq_r || !on_r),
    .div_int(div_r),
    .div_frac(trim_r),
    .clk_out(div_clk),
    .loaded(div_loaded)
  );

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REF_CLK_OUT <= 1'b0;
      REF_CLK_OE <= 1'b0;
    end else begin
      REF_CLK_OUT <= div_clk && oe_r;
      REF_CLK_OE <= oe_r && on_r;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_evt = {(status_r != status_prev_r), (div_loaded && on_r)};

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_stat_r <= '0;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_IRQ_STATUS) begin
      irq_stat_r <= (irq_stat_r & ~PWDATA[refclk_pkg::IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mask_r <= '0;
    end else if (wr_en && PADDR == refclk_pkg::ADDR_IRQ_MASK) begin
      irq_mask_r <= PWDATA[refclk_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (PADDR)
      refclk_pkg::ADDR_REF_CLOCK_CONTROL: begin
        rd_nxt[refclk_pkg::DIV_MSB:refclk_pkg::DIV_LSB] = div_r;
        rd_nxt[refclk_pkg::ON_BIT] = on_r;
        rd_nxt[refclk_pkg::SIDL_BIT] = sidl_r;
        rd_nxt[refclk_pkg::OE_BIT] = oe_r;
        rd_nxt[refclk_pkg::REF_RUN_IN_SLEEP_BIT] = ref_run_in_sleep_r;
        rd_nxt[refclk_pkg::SWREQ_BIT] = swreq_r;
        rd_nxt[refclk_pkg::ACTIVE_BIT] = active_r;
        rd_nxt[refclk_pkg::SEL_MSB:refclk_pkg::SEL_LSB] = sel_r;
      end
      refclk_pkg::ADDR_REF_CLOCK_TRIM: begin
        rd_nxt[refclk_pkg::TRIM_MSB:refclk_pkg::TRIM_LSB] = trim_r;
      end
      refclk_pkg::ADDR_CLOCK_READY_STATUS: begin
        rd_nxt[7:0] = status_r & refclk_pkg::STATUS_IMPL_MASK;
      end
      refclk_pkg::ADDR_FAST_RC_TUNING: begin
        rd_nxt[refclk_pkg::TUNE_MSB:0] = tune_r;
      end
      refclk_pkg::ADDR_IRQ_STATUS: begin
        rd_nxt[refclk_pkg::IRQ_W-1:0] = irq_stat_r;
      end
      refclk_pkg::ADDR_IRQ_MASK: begin
        rd_nxt[refclk_pkg::IRQ_W-1:0] = irq_mask_r;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Answer registered in the setup cycle so PREADY can come from a flop
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !addr_known(PADDR);
      if (PSEL && !PENABLE && !PWRITE) begin
        PRDATA <= rd_nxt;
      end
    end
  end
endmodule : refclk_top

// >>> refclk_properties.sv
// Checker for the reference clock block, seen from its top-level ports.
// Assumes it is bound onto refclk_top and that every check runs on SYS_CLK.
`timescale 1ns/100ps
module refclk_properties (
  input wire logic SYS_CLK, // Clock
  input wire logic RESET_N, // Reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB write
  input wire logic [7:0] PADDR, // APB address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic [31:0] PRDATA, // APB read data
  input wire logic PREADY, // APB ready
  input wire logic PSLVERR, // APB error
  input wire logic SLEEP_REQ, // Sleep
  input wire logic IDLE_REQ, // Idle
  input wire logic [6:0] SRC_CLK_IN, // Sources
  input wire logic [5:0] READY_IN, // Ready levels
  input wire logic REF_CLK_OUT, // Reference out
  input wire logic REF_CLK_OE, // Output enable
  input wire logic [5:0] FAST_RC_TUNE, // Tuning code
  input wire logic IRQ // Interrupt
);
  // ------------------------------------------------------------
  // Ages since last change; status and control lag a few cycles
  // ------------------------------------------------------------
  logic [3:0] rdy_age_r;
  logic [3:0] ctl_age_r;
  logic [5:0] rdy_last_r;
  wire rd_ok = PREADY && !PWRITE;
  wire rd_st = rd_ok && PADDR == refclk_pkg::ADDR_CLOCK_READY_STATUS;
  wire rd_tr = rd_ok && PADDR == refclk_pkg::ADDR_REF_CLOCK_TRIM;
  wire rd_ct = rd_ok && PADDR == refclk_pkg::ADDR_REF_CLOCK_CONTROL;
  wire wr_on = PSEL && PENABLE && PWRITE;
  wire wr_ct = wr_on && PADDR == refclk_pkg::ADDR_REF_CLOCK_CONTROL;
  wire wr_tn = wr_on && PADDR == refclk_pkg::ADDR_FAST_RC_TUNING;
  logic [1:0] key_r;
  wire tn_ok = wr_tn && key_r == 2'h2;
  wire key1 = wr_on && PADDR == refclk_pkg::ADDR_UNLOCK && PWDATA == refclk_pkg::UNLOCK_KEY1;
  wire key2 = wr_on && PADDR == refclk_pkg::ADDR_UNLOCK && PWDATA == refclk_pkg::UNLOCK_KEY2;
  // Unlock as seen on the bus: key one, then key two, spent by one tuning write
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) key_r <= 2'h0;
    else if (key1) key_r <= 2'h1;
    else if (key2 && key_r == 2'h1) key_r <= 2'h2;
    else if (wr_on && (key_r != 2'h2 || wr_tn)) key_r <= 2'h0;
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdy_last_r <= 6'h00;
      rdy_age_r <= 4'h0;
    end else begin
      rdy_last_r <= READY_IN;
      if (READY_IN != rdy_last_r) rdy_age_r <= 4'h0;
      else if (rdy_age_r != 4'hF) rdy_age_r <= rdy_age_r + 4'h1;
    end
  end
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) ctl_age_r <= 4'hF;
    else if (wr_ct) ctl_age_r <= 4'h0;
    else if (ctl_age_r != 4'hF) ctl_age_r <= ctl_age_r + 4'h1;
  end
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  trim_low_zero_a: assert property (rd_tr |-> PRDATA[22:0] == 23'h0)
    else $error("Trim low bits not zero");
  status_spare_zero_a: assert property (
    rd_st |-> {PRDATA[31:8], PRDATA[6], PRDATA[3]} == 26'h0)
    else $error("Status spare bits not zero");
  status_ready_map_a: assert property (
    rd_st && rdy_age_r >= 4'hA |->
    {PRDATA[7], PRDATA[5:4], PRDATA[2], PRDATA[0]} == {READY_IN[5:2], READY_IN[0]})
    else $error("Ready flags wrong");
  postscaler_ready_a: assert property (
    rd_st && rdy_age_r >= 4'hA |-> PRDATA[1] == READY_IN[1])
    else $error("Postscaler flag wrong");
  tune_reset_zero_a: assert property (
    $rose(RESET_N) |-> FAST_RC_TUNE == refclk_pkg::TUNE_RESET)
    else $error("Tuning not centred after reset");
  tune_write_only_a: assert property (
    !$stable(FAST_RC_TUNE) |-> $past(tn_ok) || $past(tn_ok, 2))
    else $error("Tuning changed without a write");
  active_tracks_on_a: assert property (
    rd_ct && ctl_age_r >= 4'h6 |-> PRDATA[8] == PRDATA[15])
    else $error("Request status differs from enable");
  switch_clears_a: assert property (rd_ct && ctl_age_r >= 4'h6 |-> !PRDATA[9])
    else $error("Switch request not cleared");
  cover property (rd_st && PRDATA[7]);
  cover property (wr_tn);
  cover property (rd_ct && PRDATA[15]);
endmodule : refclk_properties

bind refclk_top refclk_properties u_refclk_properties (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SLEEP_REQ(SLEEP_REQ), .IDLE_REQ(IDLE_REQ), .SRC_CLK_IN(SRC_CLK_IN), .READY_IN(READY_IN),
  .REF_CLK_OUT(REF_CLK_OUT), .REF_CLK_OE(REF_CLK_OE), .FAST_RC_TUNE(FAST_RC_TUNE), .IRQ(IRQ)
);

// >>> refclk_tb.sv
// Testbench: APB register tests and reference output rate checks.
// Assumes refclk_top; source clocks are made here with distinct periods.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic SLEEP_REQ = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [6:0] SRC_CLK_IN = 7'h00;
  logic [5:0] READY_IN = 6'h00;
  logic [31:0] PRDATA, rd, ctl_r;
  logic [5:0] FAST_RC_TUNE;
  logic PREADY, PSLVERR, REF_CLK_OUT, REF_CLK_OE, IRQ, err, last_out;
  int n_errors = 0;
  int checks_done = 0;
  int tgl = 0;
  int cyc = 0;
  // Expected output toggles in 120 cycles per selector code, divider zero
  int exp_tgl [16] = '{120, 120, 9, 10, 12, 15, 0, 20, 0, 30, 0, 0, 0, 0, 0, 0};
  logic [5:0] codes [3] = '{6'h1F, 6'h20, 6'h01};
  refclk_top u_refclk_top (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SLEEP_REQ(SLEEP_REQ), .IDLE_REQ(1'b0), .SRC_CLK_IN(SRC_CLK_IN), .READY_IN(READY_IN),
    .REF_CLK_OUT(REF_CLK_OUT), .REF_CLK_OE(REF_CLK_OE), .FAST_RC_TUNE(FAST_RC_TUNE), .IRQ(IRQ)
  );
  initial begin
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  // Source bit i has a period of 2*(i+2) cycles so each selector is told apart
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++) SRC_CLK_IN[i] <= ((cyc / (i + 2)) % 2) == 1;
    if (REF_CLK_OUT !== last_out) tgl <= tgl + 1;
    last_out <= REF_CLK_OUT;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // No wait-state limit here: a hung slave is caught by the watchdog
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask : chk_rd
  // Toggle count over 120 cycles, one off allowed for window phase
  task automatic meas(input int e);
    int t0;
    repeat (20) @(posedge SYS_CLK);
    t0 = tgl;
    repeat (120) @(posedge SYS_CLK);
    t0 = tgl - t0;
    if (t0 >= e - 1 && t0 <= e + 1) t0 = e;
    `CHK(t0, e)
  endtask : meas
  // Disable first, so the selector never moves while the request is active
  task automatic cfg(input logic [3:0] s, input logic [14:0] dv, input logic [8:0] tr,
                     input logic sl, input int e);
    logic [31:0] c;
    c = {1'b0, dv, 4'b0001, sl, 7'h00, s};
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_CONTROL, ctl_r & ~32'h0000_8000);
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_CONTROL, c);
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_TRIM, {tr, 23'h0});
    ctl_r = c | 32'h0000_8000;
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_CONTROL, ctl_r);
    meas(e);
    chk_rd(refclk_pkg::ADDR_REF_CLOCK_CONTROL, ctl_r | 32'h0000_0100);
    `CHK(REF_CLK_OE, 1'b1)
  endtask : cfg
  task automatic st(input logic [5:0] r, input logic [31:0] e);
    READY_IN <= r;
    repeat (10) @(posedge SYS_CLK);
    chk_rd(refclk_pkg::ADDR_CLOCK_READY_STATUS, e);
  endtask : st
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    ctl_r = 32'h0;
    repeat (4) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    for (int a = 0; a < 16; a += 4) chk_rd(8'(a), 32'h0);
    `CHK(REF_CLK_OE, 1'b0)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_TRIM, 32'hFFFF_FFFF);
    chk_rd(refclk_pkg::ADDR_REF_CLOCK_TRIM, 32'hFF80_0000);
    st(6'h2A, 32'h92);
    st(6'h15, 32'h25);
    st(6'h3F, 32'hB7);
    chk_rd(refclk_pkg::ADDR_IRQ_STATUS, 32'h2);
    `CHK(IRQ, 1'b0)
    apb(1'b1, refclk_pkg::ADDR_IRQ_MASK, 32'h3);
    repeat (2) @(posedge SYS_CLK);
    `CHK(IRQ, 1'b1)
    apb(1'b1, refclk_pkg::ADDR_IRQ_STATUS, 32'h2);
    chk_rd(refclk_pkg::ADDR_IRQ_STATUS, 32'h0);
    repeat (2) @(posedge SYS_CLK);
    `CHK(IRQ, 1'b0)
    apb(1'b1, refclk_pkg::ADDR_FAST_RC_TUNING, 32'h15);
    chk_rd(refclk_pkg::ADDR_FAST_RC_TUNING, 32'h0);
    foreach (codes[k]) begin
      apb(1'b1, refclk_pkg::ADDR_UNLOCK, refclk_pkg::UNLOCK_KEY1);
      apb(1'b1, refclk_pkg::ADDR_UNLOCK, refclk_pkg::UNLOCK_KEY2);
      apb(1'b1, refclk_pkg::ADDR_FAST_RC_TUNING, {26'h0, codes[k]});
      chk_rd(refclk_pkg::ADDR_FAST_RC_TUNING, {26'h0, codes[k]});
      `CHK(FAST_RC_TUNE, codes[k])
    end
    apb(1'b1, refclk_pkg::ADDR_FAST_RC_TUNING, 32'h11);
    chk_rd(refclk_pkg::ADDR_FAST_RC_TUNING, 32'h01);
    for (int s = 0; s < 16; s++) cfg(4'(s), 15'h0, 9'h0, 1'b0, exp_tgl[s]);
    cfg(4'h1, 15'h2, 9'h0, 1'b0, 60);
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_TRIM, {9'h100, 23'h0});
    meas(60);
    apb(1'b1, refclk_pkg::ADDR_IRQ_STATUS, 32'h3);
    apb(1'b1, refclk_pkg::ADDR_REF_CLOCK_CONTROL, ctl_r | 32'h0000_0200);
    meas(48);
    chk_rd(refclk_pkg::ADDR_IRQ_STATUS, 32'h1);
    `CHK(IRQ, 1'b1)
    cfg(4'h1, 15'h0, 9'h100, 1'b0, 120);
    SLEEP_REQ <= 1'b1;
    cfg(4'h0, 15'h0, 9'h0, 1'b1, 0);
    cfg(4'h1, 15'h0, 9'h0, 1'b1, 120);
    print_verdict();
  end
  // Run needs about 3500 cycles; this limit is a generous margin
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_errors++;
    print_verdict();
  end
endmodule : testbench
